/* core/afm_fmt_decode.sv */
`default_nettype none
// decodes the four-bit serial format code
module afm_fmt_decode (
	// code
	input wire logic [3:0] code_in,
	// decoded format
	output afm_pkg::afm_fmt_t fmt_out
);
	// three codes per mode, lengths 16/20/24
	always_comb begin
		fmt_out.legal = (code_in <= afm_pkg::FMT_MAX_CODE);
		unique case (code_in)
			4'h0, 4'h1, 4'h2: fmt_out.just = afm_pkg::JUST_RIGHT;
			4'h3, 4'h4, 4'h5: fmt_out.just = afm_pkg::JUST_I2S;
			4'h6, 4'h7, 4'h8: fmt_out.just = afm_pkg::JUST_LEFT;
			default: fmt_out.just = afm_pkg::JUST_BAD;
		endcase
		unique case (code_in)
			4'h0, 4'h3, 4'h6: fmt_out.word_len = 5'h10;
			4'h1, 4'h4, 4'h7: fmt_out.word_len = 5'h14;
			4'h2, 4'h5, 4'h8: fmt_out.word_len = 5'h18;
			default: fmt_out.word_len = 5'h00;
		endcase
	end
endmodule : afm_fmt_decode
`default_nettype wire

/* core/afm_mute_ramp.sv */
`default_nettype none
// one channel gain ramp toward mute or full level
module afm_mute_ramp #(
	parameter int GAIN_W = 8
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic step_in,
	input wire logic mute_in,
	// gain
	output logic [GAIN_W-1:0] gain_out,
	output logic muted_out
);
	localparam logic [GAIN_W-1:0] FULL = {GAIN_W{1'b1}};
	// state of this ramp
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
	} afm_ramp_t;
	afm_ramp_t st_reg;
	afm_ramp_t st_next;
	// one step per enable pulse, never a jump
	always_comb begin
		st_next = st_reg;
		if (step_in) begin
			if (mute_in && st_reg.gain != '0) begin
				st_next.gain = st_reg.gain - 1'b1;
			end else if (!mute_in && st_reg.gain != FULL) begin
				st_next.gain = st_reg.gain + 1'b1;
			end
		end
	end
	// registers start at full gain
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			st_reg.gain <= FULL;
		end else begin
			st_reg <= st_next;
		end
	end
	assign gain_out = st_reg.gain;
	assign muted_out = (st_reg.gain == '0);
endmodule : afm_mute_ramp
`default_nettype wire

/* core/afm_regs.sv */
`default_nettype none
// Behaviour
// - nine serial formats chosen by bus writes
// - codes 0-8 decode RJ/I2S/LJ, rest illegal
// - soft-mute bit n mutes channel n+1
// - energy flags sticky, cleared by written zero
// - satellite low and high energy flags
// - sub-woofer low and high energy flags
// - low nibble picks shared automute delay
// - high nibble picks input automute threshold
// - thresholds relative to full scale, approximate
module afm_regs #(
	parameter int CHANNELS = 8,
	parameter int GAIN_W = 8
) (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_N_IN,
	// register access from the control bus engine
	input afm_pkg::afm_req_t REQ_IN,
	output logic [7:0] RDATA_OUT,
	output logic RVALID_OUT,
	// energy events from the datapath
	input wire logic SAT_BELOW_LOW_IN,
	input wire logic SAT_ABOVE_HIGH_IN,
	input wire logic SUB_BELOW_LOW_IN,
	input wire logic SUB_ABOVE_HIGH_IN,
	// serial format for output and fifth input
	output afm_pkg::afm_fmt_t SERIAL_FORMAT_OUT,
	// soft mute
	output logic [CHANNELS-1:0] SOFT_MUTE_OUT,
	output logic [CHANNELS*GAIN_W-1:0] CHANNEL_GAIN_OUT,
	output logic [CHANNELS-1:0] CHANNEL_MUTED_OUT,
	// automute settings
	output logic [31:0] AUTOMUTE_DELAY_CYC_OUT,
	output logic [3:0] AUTOMUTE_THRESHOLD_OUT,
	output logic [7:0] AUTOMUTE_THRESHOLD_DB_OUT
);
	// all state of the block except the per-channel gain ramps
	typedef struct packed {
		logic [7:0] serial_format;
		logic [7:0] soft_mute;
		logic [7:0] energy_status;
		logic [7:0] automute;
		logic [7:0] rdata;
		logic rvalid;
		logic [15:0] step_cnt;
		logic step;
		logic [31:0] delay_cyc;
	} afm_state_t;
	afm_state_t st_reg;
	afm_state_t st_next;
	// hits on the four registers
	logic hit_fmt;
	logic hit_mute;
	logic hit_energy;
	logic hit_auto;
	logic [3:0] energy_evt;
	logic [3:0] dly_code;
	logic [3:0] thr_code;

	assign hit_fmt = (REQ_IN.addr == afm_pkg::OFS_SERIAL_FORMAT);
	assign hit_mute = (REQ_IN.addr == afm_pkg::OFS_SOFT_MUTE);
	assign hit_energy = (REQ_IN.addr == afm_pkg::OFS_ENERGY_STATUS);
	assign hit_auto = (REQ_IN.addr == afm_pkg::OFS_AUTOMUTE);
	// energy events packed in flag order
	assign energy_evt = {SUB_ABOVE_HIGH_IN, SUB_BELOW_LOW_IN,
		SAT_ABOVE_HIGH_IN, SAT_BELOW_LOW_IN};
	assign dly_code = st_reg.automute[afm_pkg::DLY_LSB +: 4];
	assign thr_code = st_reg.automute[afm_pkg::THR_LSB +: 4];

	// next-state logic: writes, reads, sticky flags, ramp pacing
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		// writes to configuration
		if (REQ_IN.wr && hit_fmt) begin
			st_next.serial_format = REQ_IN.wdata;
		end
		if (REQ_IN.wr && hit_mute) begin
			st_next.soft_mute = REQ_IN.wdata;
		end
		if (REQ_IN.wr && hit_auto) begin
			st_next.automute = REQ_IN.wdata;
		end
		// written zero clears a flag, written one keeps it
		if (REQ_IN.wr && hit_energy) begin
			st_next.energy_status[3:0] = st_reg.energy_status[3:0] & REQ_IN.wdata[3:0];
		end
		// events set flags, winning over a clear in the same cycle
		st_next.energy_status[3:0] = st_next.energy_status[3:0] | energy_evt;
		st_next.energy_status[7:4] = 4'h0;
		// reads answer one cycle later, unmapped reads zero
		if (REQ_IN.rd) begin
			st_next.rvalid = 1'b1;
			if (hit_fmt) begin
				st_next.rdata = st_reg.serial_format;
			end else if (hit_mute) begin
				st_next.rdata = st_reg.soft_mute;
			end else if (hit_energy) begin
				st_next.rdata = st_reg.energy_status;
			end else if (hit_auto) begin
				st_next.rdata = st_reg.automute;
			end else begin
				st_next.rdata = 8'h00;
			end
		end
		// divider giving the ramp step enable
		st_next.step = 1'b0;
		if (st_reg.step_cnt == 16'(afm_pkg::RAMP_STEP_CYC - 1)) begin
			st_next.step_cnt = 16'h0000;
			st_next.step = 1'b1;
		end else begin
			st_next.step_cnt = st_reg.step_cnt + 16'h0001;
		end
		// automute delay in clock cycles from the selected code
		st_next.delay_cyc = 32'(afm_pkg::DLY_US[dly_code] * (afm_pkg::CLK_HZ / 1000000));
	end

	// state register with synchronous reset
	always_ff @(posedge CLOCK_IN) begin
		if (!RST_N_IN) begin
			st_reg.serial_format <= afm_pkg::RST_SERIAL_FORMAT;
			st_reg.soft_mute <= afm_pkg::RST_SOFT_MUTE;
			st_reg.energy_status <= afm_pkg::RST_ENERGY_STATUS;
			st_reg.automute <= afm_pkg::RST_AUTOMUTE;
			st_reg.rdata <= 8'h00;
			st_reg.rvalid <= 1'b0;
			st_reg.step_cnt <= 16'h0000;
			st_reg.step <= 1'b0;
			st_reg.delay_cyc <= 32'h0000_0000;
		end else begin
			st_reg <= st_next;
		end
	end

	// format decoder
	afm_fmt_decode u_fmt (
		.code_in(st_reg.serial_format[afm_pkg::FMT_LSB +: 4]),
		.fmt_out(SERIAL_FORMAT_OUT)
	);

	// one gain ramp per channel
	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_ramp
			afm_mute_ramp #(
				.GAIN_W(GAIN_W)
			) u_ramp (
				.clk_in(CLOCK_IN),
				.rst_n_in(RST_N_IN),
				.step_in(st_reg.step),
				.mute_in(st_reg.soft_mute[ch]),
				.gain_out(CHANNEL_GAIN_OUT[ch*GAIN_W +: GAIN_W]),
				.muted_out(CHANNEL_MUTED_OUT[ch])
			);
		end
	endgenerate

	// outputs
	assign SOFT_MUTE_OUT = st_reg.soft_mute[CHANNELS-1:0];
	assign RDATA_OUT = st_reg.rdata;
	assign RVALID_OUT = st_reg.rvalid;
	assign AUTOMUTE_DELAY_CYC_OUT = st_reg.delay_cyc;
	assign AUTOMUTE_THRESHOLD_OUT = thr_code;
	// threshold magnitude below full scale, approximate; reserved codes clamp
	assign AUTOMUTE_THRESHOLD_DB_OUT = (thr_code > afm_pkg::THR_MAX_CODE) ? 8'h2A :
		8'(8'h5A - 8'(thr_code) * 8'h06);
endmodule : afm_regs
`default_nettype wire

/* inc/afm_pkg.sv */
`default_nettype none
package afm_pkg;
	// register indices on the control bus
	localparam logic [7:0] OFS_SERIAL_FORMAT = 8'h0E;
	localparam logic [7:0] OFS_SOFT_MUTE = 8'h0F;
	localparam logic [7:0] OFS_ENERGY_STATUS = 8'h10;
	localparam logic [7:0] OFS_AUTOMUTE = 8'h14;
	// values after reset
	localparam logic [7:0] RST_SERIAL_FORMAT = 8'h05;
	localparam logic [7:0] RST_SOFT_MUTE = 8'h00;
	localparam logic [7:0] RST_ENERGY_STATUS = 8'h00;
	localparam logic [7:0] RST_AUTOMUTE = 8'h00;
	// field positions
	localparam int FMT_LSB = 0;
	localparam int DLY_LSB = 0;
	localparam int THR_LSB = 4;
	localparam int EN_SAT_LOW = 0;
	localparam int EN_SAT_HIGH = 1;
	localparam int EN_SUB_LOW = 2;
	localparam int EN_SUB_HIGH = 3;
	// highest legal codes
	localparam logic [3:0] FMT_MAX_CODE = 4'h8;
	localparam logic [3:0] THR_MAX_CODE = 4'h8;
	// clock and mute ramp timing
	localparam int CLK_HZ = 10000000;
	localparam int RAMP_STEP_US = 10;
	localparam int RAMP_STEP_CYC = (RAMP_STEP_US * (CLK_HZ / 1000000) > 0) ?
		RAMP_STEP_US * (CLK_HZ / 1000000) : 1;
	// automute delay in microseconds per code
	localparam int DLY_US [16] = '{2980, 4470, 5960, 7450, 14900, 29800, 44700, 59600,
		74500, 89400, 104300, 119200, 134100, 149000, 163900, 178800};
	// serial justification modes
	typedef enum logic [3:0] {
		JUST_RIGHT = 4'h1,
		JUST_I2S = 4'h2,
		JUST_LEFT = 4'h4,
		JUST_BAD = 4'h8
	} afm_just_t;
	// decoded serial word format
	typedef struct packed {
		afm_just_t just;
		logic [4:0] word_len;
		logic legal;
	} afm_fmt_t;
	// register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} afm_req_t;
endpackage : afm_pkg
`default_nettype wire

/* tb/afm_host.sv */
`default_nettype none
// control bus master issuing single-byte register cycles
module afm_host (
	// clock and read answer
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	// request toward the bank
	output var afm_pkg::afm_req_t req_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle from time zero; no read or write is requested
	initial req_out = '0;
	// write one byte, held until the next call replaces it
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in) req_out = '{1'b1, 1'b0, a, d};
	endtask : put
	// release the bus for one cycle
	task automatic idle();
		@(negedge clk_in) req_out = '0;
	endtask : idle
	// read one byte; the answer stands one cycle after the request
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in) req_out = '{1'b0, 1'b1, a, 8'h00};
		idle();
		d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
	endtask : get
endmodule : afm_host
`default_nettype wire

/* tb/afm_regs_checker.sv */
`default_nettype none
// port-level checks of the register bank
module afm_regs_checker #(parameter int CHANNELS = 8, parameter int GAIN_W = 8) (
	// clock, reset and bus
	input wire logic CLOCK_IN, RST_N_IN, RVALID_OUT,
	input wire afm_pkg::afm_req_t REQ_IN,
	input wire logic [7:0] RDATA_OUT, AUTOMUTE_THRESHOLD_DB_OUT,
	// events and settings
	input wire logic SAT_BELOW_LOW_IN, SAT_ABOVE_HIGH_IN, SUB_BELOW_LOW_IN, SUB_ABOVE_HIGH_IN,
	input wire logic [CHANNELS-1:0] SOFT_MUTE_OUT,
	input wire logic [CHANNELS*GAIN_W-1:0] CHANNEL_GAIN_OUT,
	input wire afm_pkg::afm_fmt_t SERIAL_FORMAT_OUT,
	input wire logic [31:0] AUTOMUTE_DELAY_CYC_OUT,
	input wire logic [3:0] AUTOMUTE_THRESHOLD_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	// events in status order, written address (FF when idle), data, channel 1 gain
	wire logic [3:0] ev = {SUB_ABOVE_HIGH_IN, SUB_BELOW_LOW_IN, SAT_ABOVE_HIGH_IN, SAT_BELOW_LOW_IN};
	wire logic [7:0] wa = REQ_IN.wr ? REQ_IN.addr : 8'hFF;
	wire logic [7:0] d = REQ_IN.wdata;
	wire logic [7:0] g = CHANNEL_GAIN_OUT[7:0];
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);
	a_read_answer: assert property (REQ_IN.rd |=> RVALID_OUT)
		else $error("read not answered");
	a_fmt_illegal: assert property (wa == 8'h0E && d[3:0] > 4'h8 |=> !SERIAL_FORMAT_OUT.legal)
		else $error("illegal format accepted");
	a_mute_bits: assert property (wa == 8'h0F |=> SOFT_MUTE_OUT == $past(d))
		else $error("soft mute bits wrong");
	a_flag_set: assert property (REQ_IN.rd && REQ_IN.addr == 8'h10 && $past(RST_N_IN) |=>
		RDATA_OUT == {4'h0, RDATA_OUT[3:0] | $past(ev, 2)}) else $error("energy flag lost");
	a_flag_clear: assert property (wa == 8'h10 && d == 8'h00 && ev == 4'h0 ##1
		REQ_IN.rd && REQ_IN.addr == 8'h10 && ev == 4'h0 |=> RDATA_OUT == 8'h00)
		else $error("energy flag not cleared");
	a_delay_map: assert property (wa == 8'h14 |=> ##1 AUTOMUTE_DELAY_CYC_OUT ==
		afm_pkg::DLY_US[$past(d[3:0], 2)] * 10) else $error("automute delay wrong");
	a_thr_map: assert property (wa == 8'h14 && d[7:4] < 4'h9 |=> {AUTOMUTE_THRESHOLD_OUT,
		AUTOMUTE_THRESHOLD_DB_OUT} == {$past(d[7:4]), 8'(90 - 6 * $past(d[7:4]))})
		else $error("automute threshold wrong");
	a_ramp_step: assert property (g == $past(g) || g == $past(g) + 8'h01 || g == $past(g) - 8'h01)
		else $error("gain jumped");
	// main scenarios reached
	c_muted: cover property (g == 8'h00);
	c_read: cover property (RVALID_OUT);
	c_delay: cover property (wa == 8'h14);
endmodule : afm_regs_checker
bind afm_regs afm_regs_checker #(.CHANNELS(CHANNELS), .GAIN_W(GAIN_W)) afm_regs_checker_i (
	.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .RVALID_OUT(RVALID_OUT), .REQ_IN(REQ_IN),
	.RDATA_OUT(RDATA_OUT), .AUTOMUTE_THRESHOLD_DB_OUT(AUTOMUTE_THRESHOLD_DB_OUT),
	.SAT_BELOW_LOW_IN(SAT_BELOW_LOW_IN), .SAT_ABOVE_HIGH_IN(SAT_ABOVE_HIGH_IN),
	.SUB_BELOW_LOW_IN(SUB_BELOW_LOW_IN), .SUB_ABOVE_HIGH_IN(SUB_ABOVE_HIGH_IN),
	.SOFT_MUTE_OUT(SOFT_MUTE_OUT), .CHANNEL_GAIN_OUT(CHANNEL_GAIN_OUT),
	.SERIAL_FORMAT_OUT(SERIAL_FORMAT_OUT), .AUTOMUTE_DELAY_CYC_OUT(AUTOMUTE_DELAY_CYC_OUT),
	.AUTOMUTE_THRESHOLD_OUT(AUTOMUTE_THRESHOLD_OUT));
`default_nettype wire

/* tb/tb_afm_regs.sv */
`default_nettype none
// register cycles and energy events against the register map
module tb_afm_regs;
	timeunit 1ns;
	timeprecision 1ns;
	// clock, reset, events and design outputs
	logic CLOCK_IN = 1'b0;
	logic RST_N_IN = 1'b0;
	logic [3:0] ev = 4'h0;
	afm_pkg::afm_req_t req;
	afm_pkg::afm_fmt_t fmt;
	logic [7:0] rdata, rd, sm, mu, db;
	logic rvalid;
	logic [63:0] gn;
	logic [31:0] dc;
	logic [3:0] th;
	int fail_count = 0;
	int checks_done = 0;
	int n;
	// probed offsets and values after reset, 0x11 is unmapped
	localparam logic [7:0] OFS [5] = '{8'h0E, 8'h0F, 8'h10, 8'h14, 8'h11};
	localparam logic [7:0] RST [5] = '{afm_pkg::RST_SERIAL_FORMAT, afm_pkg::RST_SOFT_MUTE,
		afm_pkg::RST_ENERGY_STATUS, afm_pkg::RST_AUTOMUTE, 8'h00};
	initial forever #50 CLOCK_IN = ~CLOCK_IN;
	afm_host afm_host_i (.clk_in(CLOCK_IN), .rdata_in(rdata), .rvalid_in(rvalid), .req_out(req));
	afm_regs afm_regs_i (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .REQ_IN(req),
		.RDATA_OUT(rdata), .RVALID_OUT(rvalid), .SAT_BELOW_LOW_IN(ev[0]),
		.SAT_ABOVE_HIGH_IN(ev[1]), .SUB_BELOW_LOW_IN(ev[2]), .SUB_ABOVE_HIGH_IN(ev[3]),
		.SERIAL_FORMAT_OUT(fmt), .SOFT_MUTE_OUT(sm), .CHANNEL_GAIN_OUT(gn),
		.CHANNEL_MUTED_OUT(mu), .AUTOMUTE_DELAY_CYC_OUT(dc), .AUTOMUTE_THRESHOLD_OUT(th),
		.AUTOMUTE_THRESHOLD_DB_OUT(db));
	// one comparison, counted
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// main sequence
	initial begin
		repeat (6) @(negedge CLOCK_IN);
		RST_N_IN = 1'b1;
		foreach (OFS[i]) begin
			afm_host_i.get(OFS[i], rd);
			chk(rd, RST[i]);
		end
		$display("reset test done");
		// every format code, illegal ones too
		for (int c = 0; c < 16; c++) begin
			afm_host_i.put(8'h0E, 8'(c));
			afm_host_i.idle();
			chk(fmt, (c > 8) ? 10'h200 : {4'(1 << (c / 3)), 5'(16 + 4 * (c % 3)), 1'b1});
		end
		// mute channels 1 and 8, wait for the ramp, then release
		afm_host_i.put(8'h0F, 8'h81);
		afm_host_i.idle();
		chk(sm, 8'h81);
		for (n = 0; n < 40000 && mu !== 8'h81; n++) @(negedge CLOCK_IN);
		chk({n > 20000, mu, gn[15:8]}, 17'h181FF);
		afm_host_i.put(8'h0F, 8'h00);
		afm_host_i.idle();
		chk({sm, gn[7:0] < 8'h03}, 9'h001);
		$display("mute test done");
		// sticky energy flags
		@(negedge CLOCK_IN) ev = 4'h1;
		@(negedge CLOCK_IN) ev = 4'h0;
		afm_host_i.get(8'h10, rd);
		chk(rd, 8'h01);
		// a written one keeps the flag, a written zero clears it
		afm_host_i.put(8'h10, 8'h01);
		afm_host_i.get(8'h10, rd);
		chk(rd, 8'h01);
		afm_host_i.put(8'h10, 8'h00);
		afm_host_i.get(8'h10, rd);
		chk(rd, 8'h00);
		// event in the same cycle as a clearing write: the set wins
		afm_host_i.put(8'h10, 8'h00);
		ev = 4'h1;
		afm_host_i.get(8'h10, rd);
		ev = 4'h0;
		chk(rd, 8'h01);
		afm_host_i.put(8'h10, 8'h00);
		afm_host_i.get(8'h10, rd);
		chk(rd, 8'h00);
		@(negedge CLOCK_IN) ev = 4'hF;
		@(negedge CLOCK_IN) ev = 4'h0;
		afm_host_i.get(8'h10, rd);
		chk(rd, 8'h0F);
		afm_host_i.put(8'h10, 8'h0A);
		afm_host_i.get(8'h10, rd);
		chk(rd, 8'h0A);
		$display("energy test done");
		// every delay code with legal threshold codes
		for (int c = 0; c < 16; c++) begin
			afm_host_i.put(8'h14, {4'(c % 9), 4'(c)});
			afm_host_i.idle();
			afm_host_i.idle();
			chk(dc, afm_pkg::DLY_US[c] * (afm_pkg::CLK_HZ / 1000000));
			chk({th, db}, {4'(c % 9), 8'(90 - 6 * (c % 9))});
		end
		$display("automute test done");
		stop_test();
	end
	// hang guard
	initial begin
		repeat (70000) @(posedge CLOCK_IN);
		fail_count++;
		stop_test();
	end
endmodule : tb_afm_regs
`default_nettype wire
